//--- rtl/csbu_pkg.sv
// Shared constants, encodings and state types of the compare, skip and branch unit.
`default_nettype none
package csbu_pkg;
  localparam int unsigned CSBU_PC_W  = 16;
  localparam int unsigned CSBU_INS_W = 16;

  // Opcode field and opcode values; the encoding belongs to this core only.
  localparam int unsigned CSBU_OP_MSB = 15;
  localparam int unsigned CSBU_OP_LSB = 12;
  localparam logic [3:0] CSBU_OP_COMPARE_IMMEDIATE      = 4'h0;
  localparam logic [3:0] CSBU_OP_SKIP_REG_BIT_CLEAR     = 4'h1;
  localparam logic [3:0] CSBU_OP_SKIP_REG_BIT_SET       = 4'h2;
  localparam logic [3:0] CSBU_OP_SKIP_IO_BIT_CLEAR      = 4'h3;
  localparam logic [3:0] CSBU_OP_SKIP_IO_BIT_SET        = 4'h4;
  localparam logic [3:0] CSBU_OP_BRANCH_STATUS_BIT_SET  = 4'h5;
  localparam logic [3:0] CSBU_OP_BRANCH_STATUS_BIT_CLR  = 4'h6;
  localparam logic [3:0] CSBU_OP_BRANCH_GE_SIGNED       = 4'h7;
  localparam logic [3:0] CSBU_OP_BRANCH_EQUAL           = 4'h8;
  localparam logic [3:0] CSBU_OP_BRANCH_NOT_EQUAL       = 4'h9;
  localparam logic [3:0] CSBU_OP_BRANCH_CARRY_SET       = 4'hA;
  localparam logic [3:0] CSBU_OP_BRANCH_CARRY_CLEAR     = 4'hB;
  // Unsigned compares share the carry encodings.
  localparam logic [3:0] CSBU_OP_BRANCH_LOWER           = CSBU_OP_BRANCH_CARRY_SET;
  localparam logic [3:0] CSBU_OP_BRANCH_SAME_OR_HIGHER  = CSBU_OP_BRANCH_CARRY_CLEAR;

  // Operand fields.
  localparam int unsigned CSBU_IMM_MSB = 11;
  localparam int unsigned CSBU_IMM_LSB = 4;
  localparam int unsigned CSBU_RD_MSB  = 3;
  localparam int unsigned CSBU_RD_LSB  = 0;
  localparam int unsigned CSBU_REG_MSB = 8;
  localparam int unsigned CSBU_REG_LSB = 4;
  localparam int unsigned CSBU_IO_MSB  = 9;
  localparam int unsigned CSBU_IO_LSB  = 4;
  localparam int unsigned CSBU_BIT_MSB = 2;
  localparam int unsigned CSBU_BIT_LSB = 0;
  localparam int unsigned CSBU_OFS_MSB = 9;
  localparam int unsigned CSBU_OFS_LSB = 3;
  // Compare only reaches the upper half of the working registers.
  localparam logic CSBU_CMP_REG_BASE = 1'b1;

  // Status register bit positions.
  localparam logic [2:0] CSBU_FLAG_C = 3'h0;
  localparam logic [2:0] CSBU_FLAG_Z = 3'h1;
  localparam logic [2:0] CSBU_FLAG_N = 3'h2;
  localparam logic [2:0] CSBU_FLAG_V = 3'h3;
  localparam logic [2:0] CSBU_FLAG_H = 3'h5;

  // Program counter steps in words.
  localparam logic [1:0] CSBU_STEP_SEQ   = 2'h1;
  localparam logic [1:0] CSBU_STEP_SKIP1 = 2'h2;
  localparam logic [1:0] CSBU_STEP_SKIP2 = 2'h3;

  localparam logic [CSBU_PC_W-1:0] CSBU_PC_RST     = 16'h0000;
  localparam logic [7:0]           CSBU_STATUS_RST = 8'h00;

  typedef enum logic [2:0] {
    CSBU_S_EXEC  = 3'b001,
    CSBU_S_WAIT2 = 3'b010,
    CSBU_S_WAIT1 = 3'b100
  } csbu_state_e;

  typedef struct packed {
    csbu_state_e            state;
    logic [CSBU_PC_W-1:0]   pc;
    logic [7:0]             status;
    logic                   bad_op;
  } csbu_st_s;
endpackage
`default_nettype wire

//--- rtl/csbu_compare.sv
// Flag generation for compare with immediate.
`default_nettype none
module csbu_compare (
  input  wire logic [7:0] rd,
  input  wire logic [7:0] imm,
  output logic            z,
  output logic            n,
  output logic            v,
  output logic            c,
  output logic            h
);
  logic [8:0] diff;
  logic [7:0] res;

  always_comb begin
    diff = {1'b0, rd} - {1'b0, imm};
    res  = diff[7:0];
    z    = (res == 8'h00);
    n    = res[7];
    c    = diff[8];
    v    = (rd[7] & ~imm[7] & ~res[7]) | (~rd[7] & imm[7] & res[7]);
    h    = (~rd[3] & imm[3]) | (imm[3] & res[3]) | (res[3] & ~rd[3]);
  end
endmodule
`default_nettype wire

//--- rtl/csbu_pc_next.sv
// Next program counter: sequential step, skip step or relative branch target.
`default_nettype none
module csbu_pc_next #(
  parameter int unsigned PC_W = 16
) (
  input  wire logic [PC_W-1:0] pc,
  input  wire logic            skip,
  input  wire logic            skip_two,
  input  wire logic            branch,
  input  wire logic [6:0]      ofs,
  output logic      [PC_W-1:0] npc
);
  logic [PC_W-1:0] sext;
  logic [1:0]      step;

  always_comb begin
    // The offset is two's complement so backward loops are reachable.
    sext = {{(PC_W-7){ofs[6]}}, ofs};
    step = csbu_pkg::CSBU_STEP_SEQ;
    if (skip) begin
      step = skip_two ? csbu_pkg::CSBU_STEP_SKIP2 : csbu_pkg::CSBU_STEP_SKIP1;
    end
    if (branch) begin
      npc = pc + {{(PC_W-1){1'b0}}, 1'b1} + sext;
    end else begin
      npc = pc + {{(PC_W-2){1'b0}}, step};
    end
  end
endmodule
`default_nettype wire

//--- rtl/csbu_top.sv
// Compare, conditional skip and conditional branch execution with program counter and flags.
`default_nettype none
module csbu_top (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        INSTR_VALID,
  input  wire logic [15:0] INSTR,
  output logic             INSTR_READY,
  input  wire logic        NEXT_TWO_WORD,
  output logic      [4:0]  REG_ADDR,
  input  wire logic [7:0]  REG_DATA,
  output logic      [5:0]  IO_ADDR,
  input  wire logic [7:0]  IO_DATA,
  input  wire logic        STATUS_WE,
  input  wire logic [7:0]  STATUS_WDATA,
  output logic      [15:0] PC,
  output logic      [7:0]  STATUS,
  output logic             BAD_OP
);
  csbu_pkg::csbu_st_s st;
  csbu_pkg::csbu_st_s next_st;

  logic       take;
  logic [3:0] op;
  logic [2:0] bsel;
  logic [6:0] ofs;
  logic [7:0] imm;
  logic       is_cmp;
  logic       is_skip;
  logic       is_branch;
  logic       hit;
  logic       known;
  logic       f_z;
  logic       f_n;
  logic       f_v;
  logic       f_c;
  logic       f_h;
  logic [15:0] npc;

  assign take = INSTR_VALID & INSTR_READY;
  assign op   = INSTR[csbu_pkg::CSBU_OP_MSB:csbu_pkg::CSBU_OP_LSB];
  assign bsel = INSTR[csbu_pkg::CSBU_BIT_MSB:csbu_pkg::CSBU_BIT_LSB];
  assign ofs  = INSTR[csbu_pkg::CSBU_OFS_MSB:csbu_pkg::CSBU_OFS_LSB];
  assign imm  = INSTR[csbu_pkg::CSBU_IMM_MSB:csbu_pkg::CSBU_IMM_LSB];

  // Operand addresses are decoded straight from the instruction so that the
  // register file and I/O space answer within the same cycle.
  always_comb begin
    if (op == csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE) begin
      REG_ADDR = {csbu_pkg::CSBU_CMP_REG_BASE,
                  INSTR[csbu_pkg::CSBU_RD_MSB:csbu_pkg::CSBU_RD_LSB]};
    end else begin
      REG_ADDR = INSTR[csbu_pkg::CSBU_REG_MSB:csbu_pkg::CSBU_REG_LSB];
    end
  end
  assign IO_ADDR = INSTR[csbu_pkg::CSBU_IO_MSB:csbu_pkg::CSBU_IO_LSB];

  csbu_compare u_cmp (
    .rd  (REG_DATA),
    .imm (imm),
    .z   (f_z),
    .n   (f_n),
    .v   (f_v),
    .c   (f_c),
    .h   (f_h)
  );

  // Condition decode.
  always_comb begin
    is_cmp    = 1'b0;
    is_skip   = 1'b0;
    is_branch = 1'b0;
    hit       = 1'b0;
    known     = 1'b1;
    unique case (op)
      csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE: begin
        is_cmp = 1'b1;
      end
      csbu_pkg::CSBU_OP_SKIP_REG_BIT_CLEAR: begin
        is_skip = 1'b1;
        hit     = ~REG_DATA[bsel];
      end
      csbu_pkg::CSBU_OP_SKIP_REG_BIT_SET: begin
        is_skip = 1'b1;
        hit     = REG_DATA[bsel];
      end
      csbu_pkg::CSBU_OP_SKIP_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        hit     = ~IO_DATA[bsel];
      end
      csbu_pkg::CSBU_OP_SKIP_IO_BIT_SET: begin
        is_skip = 1'b1;
        hit     = IO_DATA[bsel];
      end
      csbu_pkg::CSBU_OP_BRANCH_STATUS_BIT_SET: begin
        is_branch = 1'b1;
        hit       = st.status[bsel];
      end
      csbu_pkg::CSBU_OP_BRANCH_STATUS_BIT_CLR: begin
        is_branch = 1'b1;
        hit       = ~st.status[bsel];
      end
      csbu_pkg::CSBU_OP_BRANCH_GE_SIGNED: begin
        is_branch = 1'b1;
        hit       = ~(st.status[csbu_pkg::CSBU_FLAG_N]
                      ^ st.status[csbu_pkg::CSBU_FLAG_V]);
      end
      csbu_pkg::CSBU_OP_BRANCH_EQUAL: begin
        is_branch = 1'b1;
        hit       = st.status[csbu_pkg::CSBU_FLAG_Z];
      end
      csbu_pkg::CSBU_OP_BRANCH_NOT_EQUAL: begin
        is_branch = 1'b1;
        hit       = ~st.status[csbu_pkg::CSBU_FLAG_Z];
      end
      csbu_pkg::CSBU_OP_BRANCH_CARRY_SET: begin
        is_branch = 1'b1;
        hit       = st.status[csbu_pkg::CSBU_FLAG_C];
      end
      csbu_pkg::CSBU_OP_BRANCH_CARRY_CLEAR: begin
        is_branch = 1'b1;
        hit       = ~st.status[csbu_pkg::CSBU_FLAG_C];
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  csbu_pc_next #(
    .PC_W (csbu_pkg::CSBU_PC_W)
  ) u_pcn (
    .pc       (st.pc),
    .skip     (is_skip & hit),
    .skip_two (NEXT_TWO_WORD),
    .branch   (is_branch & hit),
    .ofs      (ofs),
    .npc      (npc)
  );

  // A skip holds the unit one cycle per word it passes over and a taken branch holds it one cycle,
  // which gives the 2 or 3 cycle cost without a refetch path here.
  always_comb begin
    next_st        = st;
    next_st.bad_op = 1'b0;
    if (STATUS_WE) begin
      next_st.status = STATUS_WDATA;
    end
    unique case (st.state)
      csbu_pkg::CSBU_S_EXEC: begin
        if (take) begin
          next_st.pc     = npc;
          next_st.bad_op = ~known;
          if (is_cmp) begin
            next_st.status[csbu_pkg::CSBU_FLAG_Z] = f_z;
            next_st.status[csbu_pkg::CSBU_FLAG_N] = f_n;
            next_st.status[csbu_pkg::CSBU_FLAG_V] = f_v;
            next_st.status[csbu_pkg::CSBU_FLAG_C] = f_c;
            next_st.status[csbu_pkg::CSBU_FLAG_H] = f_h;
          end
          if (is_skip & hit) begin
            next_st.state = NEXT_TWO_WORD ? csbu_pkg::CSBU_S_WAIT2
                                          : csbu_pkg::CSBU_S_WAIT1;
          end else if (is_branch & hit) begin
            next_st.state = csbu_pkg::CSBU_S_WAIT1;
          end
        end
      end
      csbu_pkg::CSBU_S_WAIT2: begin
        next_st.state = csbu_pkg::CSBU_S_WAIT1;
      end
      csbu_pkg::CSBU_S_WAIT1: begin
        next_st.state = csbu_pkg::CSBU_S_EXEC;
      end
      default: begin
        next_st.state = csbu_pkg::CSBU_S_EXEC;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st.state  <= csbu_pkg::CSBU_S_EXEC;
      st.pc     <= csbu_pkg::CSBU_PC_RST;
      st.status <= csbu_pkg::CSBU_STATUS_RST;
      st.bad_op <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign INSTR_READY = (st.state == csbu_pkg::CSBU_S_EXEC);
  assign PC          = st.pc;
  assign STATUS      = st.status;
  assign BAD_OP      = st.bad_op;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_stall1;
    !INSTR_READY ##1 INSTR_READY;
  endsequence

  sequence s_stall2;
    !INSTR_READY [*2] ##1 INSTR_READY;
  endsequence

  a_cmp_flags: assert property (
    take && op == csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE && !STATUS_WE |=>
      INSTR_READY && PC == $past(PC) + 16'h0001
      && STATUS[csbu_pkg::CSBU_FLAG_Z] == ($past(REG_DATA) == $past(imm))
      && STATUS[csbu_pkg::CSBU_FLAG_C] == ($past(REG_DATA) < $past(imm)))
    else $error("compare flags or timing wrong");

  a_skip_reg_clr: assert property (
    take && op == csbu_pkg::CSBU_OP_SKIP_REG_BIT_CLEAR && !REG_DATA[bsel]
      && !NEXT_TWO_WORD |=> PC == $past(PC) + 16'h0002 ##0 s_stall1)
    else $error("register bit clear skip wrong");

  a_skip_reg_set: assert property (
    take && op == csbu_pkg::CSBU_OP_SKIP_REG_BIT_SET && REG_DATA[bsel]
      && NEXT_TWO_WORD && !STATUS_WE |=>
      PC == $past(PC) + 16'h0003 && $stable(STATUS) ##0 s_stall2)
    else $error("register bit set skip wrong");

  a_skip_io_clr: assert property (
    take && op == csbu_pkg::CSBU_OP_SKIP_IO_BIT_CLEAR && IO_DATA[bsel] |=>
      PC == $past(PC) + 16'h0001 && INSTR_READY)
    else $error("io bit clear skip taken wrongly");

  a_skip_io_set: assert property (
    take && op == csbu_pkg::CSBU_OP_SKIP_IO_BIT_SET && IO_DATA[bsel]
      && !NEXT_TWO_WORD |=> PC == $past(PC) + 16'h0002)
    else $error("io bit set skip wrong");

  a_status_set_taken: assert property (
    take && op == csbu_pkg::CSBU_OP_BRANCH_STATUS_BIT_SET && STATUS[bsel] |=>
      PC == $past(PC) + 16'h0001 + {{9{$past(ofs[6])}}, $past(ofs)} ##0 s_stall1)
    else $error("status set branch target wrong");

  a_status_clr_fall: assert property (
    take && op == csbu_pkg::CSBU_OP_BRANCH_STATUS_BIT_CLR && STATUS[bsel] |=>
      PC == $past(PC) + 16'h0001 && INSTR_READY)
    else $error("status clear branch should fall through");

  a_equal_taken: assert property (
    take && op == csbu_pkg::CSBU_OP_BRANCH_EQUAL
      && STATUS[csbu_pkg::CSBU_FLAG_Z] |=> !INSTR_READY)
    else $error("equal branch not taken");

  a_carry_clr_fall: assert property (
    take && op == csbu_pkg::CSBU_OP_BRANCH_CARRY_CLEAR
      && STATUS[csbu_pkg::CSBU_FLAG_C] |=> INSTR_READY)
    else $error("carry clear branch taken wrongly");

  a_signed_ge_taken: assert property (
    take && op == csbu_pkg::CSBU_OP_BRANCH_GE_SIGNED
      && STATUS[csbu_pkg::CSBU_FLAG_N] == STATUS[csbu_pkg::CSBU_FLAG_V]
      |=> !INSTR_READY)
    else $error("signed ge branch not taken");

  // An offset of minus one lands on the branch word itself, which is not backward.
  a_back_branch: assert property (
    take && op == csbu_pkg::CSBU_OP_BRANCH_NOT_EQUAL && ofs[6] && ofs != 7'h7F
      && !STATUS[csbu_pkg::CSBU_FLAG_Z] && PC > 16'h0040 |=> PC < $past(PC))
    else $error("negative offset did not go backward");

  a_skip_io_hit: assert property (
    take && op == csbu_pkg::CSBU_OP_SKIP_IO_BIT_CLEAR && !IO_DATA[bsel] && !STATUS_WE
      |=> PC == $past(PC) + 16'h0002 + {15'h0000, $past(NEXT_TWO_WORD)}
      && $stable(STATUS) && !INSTR_READY)
    else $error("io bit clear skip not taken");

  a_status_clr_taken: assert property (
    take && op == csbu_pkg::CSBU_OP_BRANCH_STATUS_BIT_CLR && !STATUS[bsel] |=>
      PC == $past(PC) + 16'h0001 + {{9{$past(ofs[6])}}, $past(ofs)} ##0 s_stall1)
    else $error("status clear branch target wrong");

  a_same_higher_taken: assert property (
    take && op == csbu_pkg::CSBU_OP_BRANCH_SAME_OR_HIGHER
      && !STATUS[csbu_pkg::CSBU_FLAG_C] |=> s_stall1)
    else $error("same or higher branch not taken");

  a_unknown_pulse: assert property (
    take && op >= 4'hC |=> BAD_OP && PC == $past(PC) + 16'h0001)
    else $error("unknown opcode not flagged");

  a_unknown_idle: assert property (
    !take |=> !BAD_OP)
    else $error("fault pulse without a taken word");
endmodule
`default_nettype wire

//--- bench/csbu_test.sv
// Self-checking bench for the compare, skip and branch unit.
`default_nettype none
module csbu_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CORE_CLK;
  logic        RST_N;
  logic        INSTR_VALID;
  logic [15:0] INSTR;
  logic        INSTR_READY;
  logic        NEXT_TWO_WORD;
  logic [4:0]  REG_ADDR;
  wire  [7:0]  REG_DATA;
  logic [5:0]  IO_ADDR;
  wire  [7:0]  IO_DATA;
  logic        STATUS_WE;
  logic [7:0]  STATUS_WDATA;
  logic [15:0] PC;
  logic [7:0]  STATUS;
  logic        BAD_OP;
  logic [7:0]  regs [32];
  logic [7:0]  ios  [64];
  logic [15:0] exp_pc;
  logic [7:0]  exp_st;
  int          err_count;
  int          n_tests;

  csbu_top csbu_top_i (
    .CORE_CLK      (CORE_CLK),
    .RST_N         (RST_N),
    .INSTR_VALID   (INSTR_VALID),
    .INSTR         (INSTR),
    .INSTR_READY   (INSTR_READY),
    .NEXT_TWO_WORD (NEXT_TWO_WORD),
    .REG_ADDR      (REG_ADDR),
    .REG_DATA      (REG_DATA),
    .IO_ADDR       (IO_ADDR),
    .IO_DATA       (IO_DATA),
    .STATUS_WE     (STATUS_WE),
    .STATUS_WDATA  (STATUS_WDATA),
    .PC            (PC),
    .STATUS        (STATUS),
    .BAD_OP        (BAD_OP)
  );

  // The register file and I/O space answer in the same cycle, as the core does.
  assign REG_DATA = regs[REG_ADDR];
  assign IO_DATA  = ios[IO_ADDR];

  initial begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic load_status(input logic [7:0] v);
    STATUS_WE = 1'b1;
    STATUS_WDATA = v;
    @(negedge CORE_CLK);
    STATUS_WE = 1'b0;
    exp_st = v;
    check("status load", {8'h00, STATUS}, {8'h00, v});
  endtask

  // Offers one word and checks the answer; during the stall an unknown op is held
  // on the port, so a unit that takes it early shows a wrong count or a fault pulse.
  task automatic issue(input logic [15:0] ins, input logic two, input logic [15:0] npc,
                       input logic [15:0] stall, input logic bad);
    logic [15:0] n;
    INSTR = ins;
    NEXT_TWO_WORD = two;
    INSTR_VALID = 1'b1;
    @(negedge CORE_CLK);
    STATUS_WE = 1'b0;
    check("pc", PC, npc);
    check("status", {8'h00, STATUS}, {8'h00, exp_st});
    check("bad op", {15'h0000, BAD_OP}, {15'h0000, bad});
    n = 16'h0000;
    INSTR = 16'hC000;
    while (INSTR_READY !== 1'b1 && n < 16'h0008) begin
      @(negedge CORE_CLK);
      n++;
    end
    INSTR_VALID = 1'b0;
    check("stall", n, stall);
    if (n == 16'h0008) begin
      report_and_stop();
    end
    if (n != 16'h0000) begin
      check("pc held", PC, npc);
      check("no bad op", {15'h0000, BAD_OP}, 16'h0000);
    end
    // One idle edge, so the next word never raises valid in the step that dropped it.
    @(negedge CORE_CLK);
    exp_pc = npc;
  endtask

  function automatic logic [7:0] cmp_flags(input logic [7:0] st, input logic [7:0] a,
                                           input logic [7:0] k);
    logic [7:0] r;
    logic [7:0] f;
    r = a - k;
    f = st;
    f[csbu_pkg::CSBU_FLAG_C] = a < k;
    f[csbu_pkg::CSBU_FLAG_Z] = r == 8'h00;
    f[csbu_pkg::CSBU_FLAG_N] = r[7];
    f[csbu_pkg::CSBU_FLAG_V] = (a[7] != k[7]) && (r[7] != a[7]);
    f[csbu_pkg::CSBU_FLAG_H] = a[3:0] < k[3:0];
    return f;
  endfunction

  task automatic skip_case(input logic [3:0] op, input logic v, input logic two);
    logic [15:0] ins;
    logic        hit;
    // The tested bit differs from all its neighbours, so a wrong bit index shows.
    regs[11] = v ? 8'h40 : 8'hBF;
    ios[42] = v ? 8'h40 : 8'hBF;
    if (op < csbu_pkg::CSBU_OP_SKIP_IO_BIT_CLEAR) begin
      ins = {op, 3'b000, 5'h0B, 1'b0, 3'h6};
    end else begin
      ins = {op, 2'b00, 6'h2A, 1'b0, 3'h6};
    end
    hit = (op == csbu_pkg::CSBU_OP_SKIP_REG_BIT_CLEAR ||
           op == csbu_pkg::CSBU_OP_SKIP_IO_BIT_CLEAR) ? !v : v;
    if (hit) begin
      issue(ins, two, exp_pc + (two ? 16'h0003 : 16'h0002), two ? 16'h0002 : 16'h0001,
            1'b0);
    end else begin
      issue(ins, two, exp_pc + 16'h0001, 16'h0000, 1'b0);
    end
  endtask

  task automatic branch(input logic [3:0] op, input logic [2:0] s, input logic [6:0] k);
    logic t;
    case (op)
      csbu_pkg::CSBU_OP_BRANCH_STATUS_BIT_SET: t = exp_st[s];
      csbu_pkg::CSBU_OP_BRANCH_STATUS_BIT_CLR: t = !exp_st[s];
      csbu_pkg::CSBU_OP_BRANCH_GE_SIGNED:
        t = !(exp_st[csbu_pkg::CSBU_FLAG_N] ^ exp_st[csbu_pkg::CSBU_FLAG_V]);
      csbu_pkg::CSBU_OP_BRANCH_EQUAL: t = exp_st[csbu_pkg::CSBU_FLAG_Z];
      csbu_pkg::CSBU_OP_BRANCH_NOT_EQUAL: t = !exp_st[csbu_pkg::CSBU_FLAG_Z];
      csbu_pkg::CSBU_OP_BRANCH_LOWER: t = exp_st[csbu_pkg::CSBU_FLAG_C];
      csbu_pkg::CSBU_OP_BRANCH_SAME_OR_HIGHER: t = !exp_st[csbu_pkg::CSBU_FLAG_C];
      default: t = 1'b0;
    endcase
    if (t) begin
      issue({op, 2'b00, k, s}, 1'b0, exp_pc + 16'h0001 + {{9{k[6]}}, k}, 16'h0001,
            1'b0);
    end else begin
      issue({op, 2'b00, k, s}, 1'b0, exp_pc + 16'h0001, 16'h0000, 1'b0);
    end
  endtask

  logic [7:0] ca  [4] = '{8'h05, 8'h03, 8'h80, 8'h10};
  logic [7:0] ck  [4] = '{8'h05, 8'h05, 8'h01, 8'h01};
  logic [7:0] pat [5] = '{8'h55, 8'hAA, 8'h0F, 8'h08, 8'h00};

  initial begin
    err_count = 0;
    n_tests = 0;
    RST_N = 1'b0;
    INSTR_VALID = 1'b0;
    INSTR = 16'h0000;
    NEXT_TWO_WORD = 1'b0;
    STATUS_WE = 1'b0;
    STATUS_WDATA = 8'h00;
    for (int i = 0; i < 64; i++) begin
      ios[i] = 8'h00;
      if (i < 32) begin
        regs[i] = 8'h00;
      end
    end
    repeat (2) @(negedge CORE_CLK);
    check("reset pc", PC, 16'h0000);
    check("reset status", {8'h00, STATUS}, 16'h0000);
    check("reset ready", {15'h0000, INSTR_READY}, 16'h0001);
    RST_N = 1'b1;
    @(negedge CORE_CLK);
    exp_pc = 16'h0000;
    exp_st = 8'h00;
    load_status(8'hD0);
    for (int i = 0; i < 4; i++) begin
      regs[16 + i] = ca[i];
      exp_st = cmp_flags(exp_st, ca[i], ck[i]);
      issue({4'h0, ck[i], i[3:0]}, 1'b0, exp_pc + 16'h0001, 16'h0000, 1'b0);
    end
    // A status load in the same edge as a compare keeps only its untouched bits.
    STATUS_WE = 1'b1;
    STATUS_WDATA = 8'h3F;
    exp_st = cmp_flags(8'h3F, 8'h05, 8'h05);
    issue({4'h0, 8'h05, 4'h0}, 1'b0, exp_pc + 16'h0001, 16'h0000, 1'b0);
    for (int op = 1; op <= 4; op++) begin
      for (int v = 0; v < 2; v++) begin
        for (int t = 0; t < 2; t++) begin
          skip_case(op[3:0], v[0], t[0]);
        end
      end
    end
    for (int p = 0; p < 5; p++) begin
      load_status(pat[p]);
      for (int s = 0; s < 8; s++) begin
        branch(4'h5, s[2:0], s[0] ? 7'h7E : 7'h05);
        branch(4'h6, s[2:0], s[0] ? 7'h05 : 7'h7E);
      end
      for (int op = 7; op <= 11; op++) begin
        branch(op[3:0], 3'h0, op[0] ? 7'h40 : 7'h3F);
      end
    end
    for (int op = 12; op < 16; op++) begin
      issue({op[3:0], 12'h123}, 1'b0, exp_pc + 16'h0001, 16'h0000, 1'b1);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
